// [core/pot_defines.svh]
// constants for the potentiometer two-wire slave: addresses, reset values, timing
`ifndef POT_DEFINES_SVH
`define POT_DEFINES_SVH

// ==========================================================================
// bus address and register map
`define POT_BUS_ADDR      7'h28
`define POT_REG_WIPER     8'h00
`define POT_REG_RSVD      8'h01
`define POT_REG_ACS       8'h02

// ==========================================================================
// field positions and values
`define POT_ACS_VOL_BIT   7
`define POT_ACS_RESET     8'h00
`define POT_ACS_NV        8'h00
`define POT_ACS_VOL       8'h80
`define POT_WIPER_DEFAULT 8'h80
`define POT_NV_INIT       8'h80

// ==========================================================================
// timing
`define POT_CLK_MHZ       200
`define POT_BOOT_TIME_US  120
`define POT_BOOT_CYCLES   (`POT_BOOT_TIME_US * `POT_CLK_MHZ)
`define POT_NVW_TIME_US   10000
`define POT_NVW_CYCLES    (`POT_NVW_TIME_US * `POT_CLK_MHZ)

`endif

// [core/pot_i2c_slave.sv]
// two-wire serial slave giving access to the digital potentiometer registers
//
// Summary of operation
// - the block is only a bus slave; the master starts transfers and clocks them
// - every byte moves most significant bit first
// - data changes only while clock low; changes while high are start or stop
// - during power-up the data pin is an input, never driven
// - watch both lines for a start; ignore everything until one is seen
// - starts during power-up or a nonvolatile write are ignored
// - stop after a read or volatile-only write returns to standby
// - stop that began a nonvolatile write reaches standby when that write ends
// - transmitter releases data after eight bits; receiver pulls low on ninth clock
// - acknowledge valid address byte, register address byte and write data byte
// - first byte upper seven bits match bus address; low bit 1 read, 0 write
// - during a nonvolatile write both lines are ignored and data is released
// - write data shifts in on clock rises and commits on the falling edge after its last bit
// - write to register 0 with access-select zero starts nonvolatile write at stop
// - read is address write, register, repeated start, address read, one byte
// - access-select 00h targets power-up store, 80h targets wiper setting
// - access-select is 8 bits at 02h, only msb matters, resets to 00h
// - at power-up the power-up store is copied into the wiper setting
// - with access-select 80h register 0 touches only the wiper setting
// - writing the store also loads the wiper; reading it leaves wiper alone
// - a bad register address or a second write data byte returns the wiper setting to 128
`include "pot_defines.svh"

module pot_i2c_slave
   import pot_pkg::*;
#(
   parameter int unsigned BOOT_CYCLES = `POT_BOOT_CYCLES,
   parameter int unsigned NVW_CYCLES  = `POT_NVW_CYCLES,
   parameter logic [7:0]  NV_INIT     = `POT_NV_INIT
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // bus pins
   input  wire pot_pins_s   pins_i,
   output logic             sda_o,
   output logic             sda_oe,
   // potentiometer control and status
   output logic [7:0]       wiper_setting,
   output pot_status_s      status
);

   // =======================================================================
   // declarations
   pot_state_e  state_q;
   logic [1:0]  scl_meta_q;
   logic [1:0]  sda_meta_q;
   logic        scl_s_q;
   logic        sda_s_q;
   logic        scl_p_q;
   logic        sda_p_q;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_cond;
   logic        stop_cond;
   logic [31:0] timer_q;
   logic        timer_done;
   logic [3:0]  bit_cnt_q;
   logic [7:0]  shift_q;
   logic [7:0]  tx_q;
   logic [7:0]  ptr_q;
   logic        wrote_q;
   logic        sda_oe_q;
   logic [7:0]  wiper_q;
   logic [7:0]  acs_q;
   logic [7:0]  nv_q = NV_INIT;
   logic [7:0]  nv_data_q;
   logic        nv_pend_q;
   logic        byte_done;
   logic        ack_end;
   logic        id_match;
   logic        reg_ok;
   logic        wr_commit;
   logic        wr_error;
   logic        reg_error;
   logic [7:0]  read_value;

   // =======================================================================
   // pin synchronisers and bus condition detection
   // three flops settle the free-running pins; a fourth keeps the previous level so
   // edges and conditions are only ever formed from settled values
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scl_meta_q <= 2'h3;
         sda_meta_q <= 2'h3;
         scl_s_q    <= 1'b1;
         sda_s_q    <= 1'b1;
         scl_p_q    <= 1'b1;
         sda_p_q    <= 1'b1;
      end else begin
         scl_meta_q <= {scl_meta_q[0], pins_i.scl};
         sda_meta_q <= {sda_meta_q[0], pins_i.sda};
         scl_s_q    <= scl_meta_q[1];
         sda_s_q    <= sda_meta_q[1];
         scl_p_q    <= scl_s_q;
         sda_p_q    <= sda_s_q;
      end
   end

   assign scl_rise   = scl_s_q & ~scl_p_q;
   assign scl_fall   = ~scl_s_q & scl_p_q;
   // data moving while clock stays high marks a condition, not a bit
   assign start_cond = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   assign stop_cond  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

   // =======================================================================
   // byte framing helpers
   // the eighth falling edge closes the byte; the last bit was loaded on the rise before it
   assign byte_done  = scl_fall && bit_cnt_q == 4'd7;
   assign ack_end    = scl_fall && bit_cnt_q == 4'd8;
   assign id_match   = shift_q[7:1] == `POT_BUS_ADDR;
   assign reg_ok     = shift_q == `POT_REG_WIPER || shift_q == `POT_REG_ACS;
   assign wr_commit  = state_q == POT_ST_WDATA && byte_done && !wrote_q;
   // a second data byte in one write is outside the protocol
   assign wr_error   = state_q == POT_ST_WDATA && byte_done && wrote_q;
   assign reg_error  = state_q == POT_ST_REG && byte_done && !reg_ok;

   // register 0 reads the store unless access-select picks the wiper
   always_comb begin
      read_value = 8'h00;
      if (ptr_q == `POT_REG_WIPER) begin
         read_value = acs_q[`POT_ACS_VOL_BIT] ? wiper_q : nv_q;
      end else if (ptr_q == `POT_REG_ACS) begin
         read_value = acs_q;
      end
   end

   // =======================================================================
   // shared timer for the power-up recall and the nonvolatile write
   // one counter serves both blind phases since they never overlap; it reloads
   // whenever the block idles or holds a write, so the store write starts full
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         timer_q <= BOOT_CYCLES;
      end else if (state_q == POT_ST_WDATA || state_q == POT_ST_IDLE) begin
         timer_q <= NVW_CYCLES;
      end else if (state_q == POT_ST_BOOT || state_q == POT_ST_NVW) begin
         if (timer_q != 32'h0) begin
            timer_q <= timer_q - 32'h1;
         end
      end
   end

   assign timer_done = timer_q == 32'h0;

   // =======================================================================
   // protocol sequencer
   // boot and nvw are blind phases; every other state watches for start and stop.
   // id, reg and wdata take in a byte and acknowledge it on the ninth clock;
   // tx sends one byte, then ignore waits for the master's stop.
   // the bit counter steps on clock falls, because the master moves data while
   // the clock is low: 0 to 7 a bit in flight, 8 the ninth clock, F the fall
   // that closes a start and carries no bit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q   <= POT_ST_BOOT;
         bit_cnt_q <= 4'h0;
         shift_q   <= 8'h00;
         tx_q      <= 8'h00;
         ptr_q     <= 8'h00;
         wrote_q   <= 1'b0;
         sda_oe_q  <= 1'b0;
      end else begin
         unique case (state_q)
            POT_ST_BOOT: begin
               // starts are not looked at until the recall finishes
               sda_oe_q <= 1'b0;
               if (timer_done) begin
                  state_q <= POT_ST_IDLE;
               end
            end
            POT_ST_NVW: begin
               // both lines ignored and data released while writing
               sda_oe_q <= 1'b0;
               if (timer_done) begin
                  state_q <= POT_ST_IDLE;
               end
            end
            default: begin
               if (start_cond) begin
                  // a start anywhere drops what was under way
                  // the clock fall that closes the start carries no bit, so the
                  // counter parks one below zero and wraps on that fall
                  state_q   <= POT_ST_ID;
                  bit_cnt_q <= 4'hF;
                  sda_oe_q  <= 1'b0;
                  wrote_q   <= 1'b0;
               end else if (stop_cond) begin
                  bit_cnt_q <= 4'h0;
                  sda_oe_q  <= 1'b0;
                  // a stop with the counter at rest ends a whole frame; elsewhere it aborts
                  if (nv_pend_q && bit_cnt_q == 4'h0) begin
                     state_q <= POT_ST_NVW;
                  end else begin
                     state_q <= POT_ST_IDLE;
                  end
               end else if (state_q == POT_ST_IDLE || state_q == POT_ST_IGNORE) begin
                  sda_oe_q  <= 1'b0;
                  bit_cnt_q <= 4'h0;
               end else if (state_q == POT_ST_TX) begin
                  // device transmits, master clocks
                  if (scl_fall) begin
                     if (bit_cnt_q < 4'd7) begin
                        tx_q      <= {tx_q[6:0], 1'b0};
                        sda_oe_q  <= ~tx_q[6];
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                     end else if (bit_cnt_q == 4'd7) begin
                        sda_oe_q  <= 1'b0;
                        bit_cnt_q <= 4'd8;
                     end else begin
                        // one data byte only; wait for the master's stop
                        state_q   <= POT_ST_IGNORE;
                        bit_cnt_q <= 4'h0;
                     end
                  end
               end else begin
                  // receiving: id, register or data byte
                  if (scl_rise && bit_cnt_q < 4'd8) begin
                     shift_q <= {shift_q[6:0], sda_s_q};
                  end
                  // ack rises on the fall that closes the eighth bit and stands through the ninth clock
                  if (byte_done) begin
                     bit_cnt_q <= 4'd8;
                     unique case (state_q)
                        POT_ST_ID: begin
                           sda_oe_q <= id_match;
                           if (!id_match) begin
                              state_q <= POT_ST_IGNORE;
                           end
                        end
                        POT_ST_REG: begin
                           sda_oe_q <= reg_ok;
                           ptr_q    <= shift_q;
                           if (!reg_ok) begin
                              state_q <= POT_ST_IGNORE;
                           end
                        end
                        default: begin
                           sda_oe_q <= !wrote_q;
                           wrote_q  <= 1'b1;
                           if (wrote_q) begin
                              state_q <= POT_ST_IGNORE;
                           end
                        end
                     endcase
                  end else if (scl_fall && bit_cnt_q < 4'd7) begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end else if (scl_fall && bit_cnt_q == 4'hF) begin
                     bit_cnt_q <= 4'h0;
                  end else if (ack_end) begin
                     // ninth clock over: release and move on
                     sda_oe_q  <= 1'b0;
                     bit_cnt_q <= 4'h0;
                     if (state_q == POT_ST_ID) begin
                        if (shift_q[0]) begin
                           // first bit goes out on the same falling edge
                           state_q  <= POT_ST_TX;
                           tx_q     <= read_value;
                           sda_oe_q <= ~read_value[7];
                        end else begin
                           state_q <= POT_ST_REG;
                        end
                     end else if (state_q == POT_ST_REG) begin
                        state_q <= POT_ST_WDATA;
                     end
                  end
               end
            end
         endcase
      end
   end

   // =======================================================================
   // register file and nonvolatile store
   // the store itself has no reset: it keeps its value across sys_rst
   always_ff @(posedge clk) begin
      if (state_q == POT_ST_NVW && timer_done) begin
         nv_q <= nv_data_q;
      end
   end

   // wiper: recalled at power-up, loaded by register-0 writes, parked on errors
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wiper_q <= `POT_WIPER_DEFAULT;
      end else begin
         if (state_q == POT_ST_BOOT && timer_done) begin
            wiper_q <= nv_q;
         end
         if (wr_error || reg_error) begin
            wiper_q <= `POT_WIPER_DEFAULT;
         end else if (wr_commit && ptr_q == `POT_REG_WIPER) begin
            // store writes always carry the wiper along
            wiper_q <= shift_q;
         end
      end
   end

   // access-select: the whole byte is kept even though only bit 7 steers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         acs_q <= `POT_ACS_RESET;
      end else if (wr_commit && ptr_q == `POT_REG_ACS) begin
         // reserved values are the master's to avoid, not ours to filter
         acs_q <= shift_q;
      end
   end

   // =======================================================================
   // store write bookkeeping
   // the byte waits here for the closing stop; a start or an idle drops it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         nv_data_q <= 8'h00;
         nv_pend_q <= 1'b0;
      end else if (start_cond || state_q == POT_ST_NVW || state_q == POT_ST_IDLE) begin
         nv_pend_q <= 1'b0;
      end else if (wr_commit && ptr_q == `POT_REG_WIPER && !acs_q[`POT_ACS_VOL_BIT]) begin
         nv_data_q <= shift_q;
         nv_pend_q <= 1'b1;
      end
   end

   // =======================================================================
   // outputs
   // open-drain: the pin only ever pulls low
   assign sda_o                = 1'b0;
   assign sda_oe               = sda_oe_q;
   assign wiper_setting        = wiper_q;
   assign status.booting       = state_q == POT_ST_BOOT;
   assign status.nv_busy       = state_q == POT_ST_NVW;
   assign status.access_select = acs_q;

endmodule

// [core/pot_pkg.sv]
// types shared by the potentiometer two-wire slave
package pot_pkg;

   // ========================================================================
   // protocol states, one-hot
   typedef enum logic [7:0] {
      POT_ST_BOOT   = 8'h01,
      POT_ST_IDLE   = 8'h02,
      POT_ST_ID     = 8'h04,
      POT_ST_REG    = 8'h08,
      POT_ST_WDATA  = 8'h10,
      POT_ST_TX     = 8'h20,
      POT_ST_IGNORE = 8'h40,
      POT_ST_NVW    = 8'h80
   } pot_state_e;

   // ========================================================================
   // bus pin levels as seen at the device
   typedef struct packed {
      logic scl;
      logic sda;
   } pot_pins_s;

   // ========================================================================
   // status shown to the rest of the chip
   typedef struct packed {
      logic booting;
      logic nv_busy;
      logic [7:0] access_select;
   } pot_status_s;

endpackage

// [tb/pot_bus_master.sv]
// behavioural two-wire bus master driving the potentiometer slave
module pot_bus_master (
   // bus lines
   output logic       scl = 1'b1,
   output logic       sda_m = 1'b1,
   input  wire logic  sda_w,
   // byte results: res_t toggles as each byte completes
   output logic [7:0] res = 8'h00,
   output logic       res_t = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam time Q = 40;

   // ======================================
   // bit level, data moves mid-low so both edges stay clear
   task automatic bit_io(input logic b, output logic s);
      sda_m = b;
      #Q scl = 1'b1;
      #Q s = sda_w;
      #Q scl = 1'b0;
      #Q;
   endtask
   task automatic start();
      if (!scl) begin
         sda_m = 1'b1;
         #Q scl = 1'b1;
         #Q;
      end
      sda_m = 1'b0;
      #Q scl = 1'b0;
      #Q;
   endtask
   task automatic stop();
      sda_m = 1'b0;
      #Q scl = 1'b1;
      #Q sda_m = 1'b1;
      #Q;
   endtask
   task automatic frag(input int n);
      logic s;
      repeat (n) bit_io(1'b1, s);
   endtask

   // ======================================
   // byte level
   task automatic put(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      res = {7'h0, ~s};
      res_t = ~res_t;
   endtask
   task automatic get();
      logic       s;
      logic [7:0] d;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b0, s);
      res = d;
      res_t = ~res_t;
   endtask
endmodule

// [tb/pot_i2c_slave_sva.sv]
// port-level assertions for the potentiometer two-wire slave
module pot_i2c_slave_sva
   import pot_pkg::*;
#(
   parameter int unsigned NVW_CYCLES = 50
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        sys_rst,
   // bus pins
   input wire pot_pins_s   pins_i,
   input wire logic        sda_o,
   input wire logic        sda_oe,
   // control and status
   input wire logic [7:0]  wiper_setting,
   input wire pot_status_s status
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // ======================================
   // helpers
   // busy length is far beyond a repetition count, so count it here
   logic [31:0] busy_q;
   always_ff @(posedge clk) begin
      if (sys_rst || !status.nv_busy) busy_q <= '0;
      else busy_q <= busy_q + 32'h1;
   end
   sequence s_stop;
      pins_i.scl && !pins_i.sda ##1 pins_i.scl && pins_i.sda;
   endsequence

   // ======================================
   // properties
   chk_boot_quiet:
      assert property (status.booting |-> !sda_oe) else $error("data pin driven during power-up");
   chk_nvw_quiet:
      assert property (status.nv_busy |-> !sda_oe) else $error("data pin driven during store write");
   chk_pull_low:
      assert property (sda_oe |-> !sda_o) else $error("data pin driven high");
   chk_oe_moves_low:
      assert property ($changed(sda_oe) |-> !pins_i.scl && !$past(pins_i.scl, 2))
         else $error("data output changed outside clock low");
   chk_oe_holds:
      assert property (sda_oe && pins_i.scl |=> sda_oe) else $error("data released while clock high");
   chk_select_commit:
      assert property ($changed(status.access_select) |-> !pins_i.scl && !$past(pins_i.scl, 2))
         else $error("access select changed outside clock low");
   chk_wiper_commit:
      assert property ($changed(wiper_setting) && wiper_setting != 8'h80 && !$past(status.booting)
         && !$past(status.booting, 2) |-> !pins_i.scl) else $error("wiper changed outside clock low");
   chk_busy_after_stop:
      assert property ($rose(status.nv_busy) |-> pins_i.scl && pins_i.sda && !$past(pins_i.sda, 8))
         else $error("store write began without stop");
   chk_busy_length:
      assert property ($fell(status.nv_busy) |-> busy_q == NVW_CYCLES + 1) else $error("store write length wrong");
   chk_wiper_frozen:
      assert property (status.nv_busy |=> $stable(wiper_setting)) else $error("wiper moved during store write");
   chk_stop_idle:
      assert property (s_stop |=> !sda_oe [*8]) else $error("data driven after stop");
endmodule

bind pot_i2c_slave pot_i2c_slave_sva #(
   .NVW_CYCLES (NVW_CYCLES)
) u_pot_i2c_slave_sva (
   .clk           (clk),
   .sys_rst       (sys_rst),
   .pins_i        (pins_i),
   .sda_o         (sda_o),
   .sda_oe        (sda_oe),
   .wiper_setting (wiper_setting),
   .status        (status)
);

// [tb/tb.sv]
// self-checking bench for the potentiometer two-wire slave
module tb;
   import pot_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ACK = 8'h01;
   localparam logic [7:0] NAK = 8'h00;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        scl;
   logic        sda_m;
   logic        res_t;
   logic [7:0]  res;
   logic        sda_o;
   logic        sda_oe;
   logic [7:0]  wiper_setting;
   pot_status_s status;
   pot_pins_s   pins;
   wire logic   sda_w;
   logic [7:0]  q[$];
   int          num_errors = 0;
   int          n_tests = 0;
   int          cyc = 0;
   logic [7:0]  w;
   logic [7:0]  v;

   always #2.5 clk = ~clk;
   // open drain with pull-up: released line reads high
   assign sda_w = (sda_oe === 1'b1 && sda_o !== 1'b1) ? 1'b0 : sda_m;
   assign pins = {scl, sda_w};

   pot_i2c_slave #(
      .BOOT_CYCLES (20),
      .NVW_CYCLES  (600),
      .NV_INIT     (8'h3C)
   ) u_pot_i2c_slave (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .pins_i        (pins),
      .sda_o         (sda_o),
      .sda_oe        (sda_oe),
      .wiper_setting (wiper_setting),
      .status        (status)
   );
   pot_bus_master u_pot_bus_master (
      .scl   (scl),
      .sda_m (sda_m),
      .sda_w (sda_w),
      .res   (res),
      .res_t (res_t)
   );

   // ======================================
   // checking
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // the model's start-up value on its toggle is not a result
   always @(res_t) if ($time > 0) chk("bus byte", q.size() != 0 ? q.pop_front() : 8'hXX, res);
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         num_errors++;
         results();
      end
   end

   // ======================================
   // transfers
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic boot(input logic [7:0] e);
      for (int i = 0; i < 200 && status.booting !== 1'b0; i++) tick(1);
      tick(8);
      chk("wiper after power-up", e, wiper_setting);
      $display("test power-up done");
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      repeat (3) q.push_back(ACK);
      u_pot_bus_master.start();
      u_pot_bus_master.put(8'h50);
      u_pot_bus_master.put(a);
      u_pot_bus_master.put(d);
      u_pot_bus_master.stop();
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      repeat (3) q.push_back(ACK);
      q.push_back(e);
      u_pot_bus_master.start();
      u_pot_bus_master.put(8'h50);
      u_pot_bus_master.put(a);
      u_pot_bus_master.start();
      u_pot_bus_master.put(8'h51);
      u_pot_bus_master.get();
      u_pot_bus_master.stop();
   endtask

   initial begin
      void'($urandom(32'h96F6480A));
      tick(4);
      chk("select in reset", 8'h00, status.access_select);
      chk("oe in reset", 8'h00, {7'h0, sda_oe});
      sys_rst = 1'b0;
      boot(8'h3C);
      rd(8'h02, 8'h00);
      rd(8'h00, 8'h3C);
      wr(8'h02, 8'h80);
      repeat (3) begin
         v = 8'($urandom);
         wr(8'h00, v);
         chk("wiper", v, wiper_setting);
         chk("nv busy", 8'h00, {7'h0, status.nv_busy});
         rd(8'h00, v);
      end
      $display("test volatile done");
      wr(8'h02, 8'h00);
      w = 8'($urandom);
      wr(8'h00, w);
      tick(4);
      chk("wiper", w, wiper_setting);
      chk("nv busy", 8'h01, {7'h0, status.nv_busy});
      q.push_back(NAK);
      u_pot_bus_master.start();
      u_pot_bus_master.put(8'h50);
      u_pot_bus_master.stop();
      for (int i = 0; i < 1000 && status.nv_busy !== 1'b0; i++) tick(1);
      tick(8);
      rd(8'h00, w);
      wr(8'h02, 8'h80);
      wr(8'h00, 8'h5A);
      wr(8'h02, 8'h00);
      rd(8'h00, w);
      chk("wiper", 8'h5A, wiper_setting);
      $display("test store done");
      repeat (2) q.push_back(NAK);
      u_pot_bus_master.start();
      u_pot_bus_master.put(8'h52);
      u_pot_bus_master.put(8'h50);
      u_pot_bus_master.stop();
      repeat (2) q.push_back(ACK);
      u_pot_bus_master.start();
      u_pot_bus_master.put(8'h50);
      u_pot_bus_master.put(8'h00);
      u_pot_bus_master.frag(4);
      u_pot_bus_master.stop();
      tick(8);
      chk("wiper", 8'h5A, wiper_setting);
      chk("nv busy", 8'h00, {7'h0, status.nv_busy});
      q.push_back(ACK);
      q.push_back(NAK);
      u_pot_bus_master.start();
      u_pot_bus_master.put(8'h50);
      u_pot_bus_master.put(8'h01);
      u_pot_bus_master.stop();
      chk("wiper", 8'h80, wiper_setting);
      wr(8'h02, 8'h80);
      repeat (3) q.push_back(ACK);
      q.push_back(NAK);
      u_pot_bus_master.start();
      u_pot_bus_master.put(8'h50);
      u_pot_bus_master.put(8'h00);
      u_pot_bus_master.put(8'h11);
      u_pot_bus_master.put(8'h22);
      u_pot_bus_master.stop();
      chk("wiper", 8'h80, wiper_setting);
      $display("test errors done");
      sys_rst = 1'b1;
      tick(4);
      sys_rst = 1'b0;
      q.push_back(NAK);
      u_pot_bus_master.start();
      u_pot_bus_master.put(8'h50);
      u_pot_bus_master.stop();
      boot(w);
      rd(8'h02, 8'h00);
      results();
   end
endmodule
